/* File: logic/abs_pkg.sv */
// Constants, register map and shared types of the buffered serial engine
// Assumes a 32-bit APB master and a 20 MHz system clock
//
// What this block does
// R1 - Store received byte at counter, then increment
// R2 - Load next byte from buffer before shifting
// R3 - Last byte: store, flag, interrupt, clear busy
// R4 - Transmit-only sends programmed count of bytes
// R5 - Start needs enable, auto and transmit set
// R6 - Transmit-only increments counter, never writes buffer
// R7 - Transmit-only sets done flag after last
// R8 - Status bit 0 shows transfer in progress
// R9 - Repeat start also needs repeat select
// R10 - Repeat: no flag, counter to zero, resend
// R11 - Repeat: reload first byte, count as before
// R12 - Interval between bytes from setting, strobe, busy
// R13 - CPU buffer access may stretch the interval
// R14 - Unused input, busy, strobe pins released
// R15 - Software fills buffer, end point is count-1
// R16 - Transfer until counter reaches end point
// R17 - Shift on falling edge, store on rising
// R18 - Busy bit set at start until end
// R19 - Start is one-shot, no self restart
`default_nettype none
package abs_pkg;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned RAM_AW    = 5;
	localparam int unsigned RAM_DEPTH = 32;
	localparam int unsigned PADDR_W   = 8;

	localparam logic [7:0] OFF_MODE   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TRIG   = 8'h08;
	localparam logic [7:0] OFF_END    = 8'h0c;
	localparam logic [7:0] OFF_COUNT  = 8'h10;
	localparam logic [7:0] OFF_INTV   = 8'h14;
	localparam logic [7:0] OFF_ISTAT  = 8'h18;
	localparam logic [7:0] OFF_IMASK  = 8'h1c;
	localparam int unsigned RAM_SEL_BIT = 7;

	localparam int unsigned MODE_IFACE  = 7;
	localparam int unsigned MODE_AUTO   = 6;
	localparam int unsigned MODE_REPEAT = 5;
	localparam int unsigned MODE_TX     = 3;
	localparam int unsigned MODE_RX     = 2;
	localparam int unsigned STAT_STB    = 5;
	localparam int unsigned STAT_BUSY   = 4;
	localparam int unsigned STAT_BUSYLV = 3;
	localparam int unsigned STAT_TIP    = 0;
	localparam int unsigned TRIG_START  = 0;
	localparam int unsigned TRIG_STOP   = 1;
	localparam int unsigned IRQ_DONE    = 0;

	localparam logic [4:0] END_RST  = 5'h00;
	localparam logic [4:0] INTV_RST = 5'h00;
	localparam logic       IRQ_RST  = 1'b0;
	localparam logic [3:0] LAST_BIT = 4'h7;

	typedef struct packed {
		logic iface_enable;
		logic auto_mode_enable;
		logic repeat_select;
		logic transmit_enable;
		logic receive_enable;
	} abs_mode_t;

	localparam abs_mode_t MODE_RST = '0;

	typedef struct packed {
		logic              en;
		logic              we;
		logic [RAM_AW-1:0] addr;
		logic [BYTE_W-1:0] wdata;
	} abs_ram_req_t;

	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_FETCH = 6'h02,
		S_LATCH = 6'h04,
		S_SHIFT = 6'h08,
		S_STORE = 6'h10,
		S_GAP   = 6'h20
	} abs_state_t;

	function automatic logic busy_is_active(input logic level, input logic pin);
		return pin == level;
	endfunction : busy_is_active
endpackage : abs_pkg
`default_nettype wire

/* File: logic/abs_sync.sv */
// Two-flop synchronisers for the pin inputs
// Assumes asynchronous pins, one system clock
`default_nettype none
module abs_sync (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [2:0] d_i,
	output logic      [2:0] q_o
);
	logic [2:0] meta_r;
	logic [2:0] q_r;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			// Bit 0 is the serial clock, which idles high
			meta_r <= 3'h1;
			q_r    <= 3'h1;
		end
		else
		begin
			meta_r <= d_i;
			q_r    <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule : abs_sync
`default_nettype wire

/* File: logic/abs_buf_ram.sv */
// Transfer buffer, one port, registered read data
// Assumes the owner arbitrates the single port
`default_nettype none
module abs_buf_ram (
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	input  wire abs_pkg::abs_ram_req_t   req_i,
	output logic [abs_pkg::BYTE_W-1:0]   rdata_o
);
	logic [abs_pkg::BYTE_W-1:0] mem [abs_pkg::RAM_DEPTH];
	logic [abs_pkg::BYTE_W-1:0] rdata_r;

	always_ff @(posedge clk_i)
	begin
		if (req_i.en && req_i.we)
			mem[req_i.addr] <= req_i.wdata;
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_r <= 8'h00;
		else if (req_i.en && !req_i.we)
			rdata_r <= mem[req_i.addr];
	end

	assign rdata_o = rdata_r;
endmodule : abs_buf_ram
`default_nettype wire

/* File: logic/abs_engine.sv */
// Buffered serial transfer engine with APB registers and buffer
// Assumes serial clock, data in and busy arrive as asynchronous pins
`default_nettype none
module abs_engine (
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic             IRQ_O,
	input  wire logic        SCK_I,
	input  wire logic        SI_I,
	input  wire logic        BUSY_I,
	output logic             SO_O,
	output logic             SO_OE_O,
	output logic             STB_O,
	output logic             STB_OE_O,
	output logic             SI_RELEASE_O,
	output logic             BUSY_RELEASE_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	logic [2:0]            pins_s;
	logic                  sck_s;
	logic                  si_s;
	logic                  busy_s;
	logic                  sck_prev_r;
	logic                  sck_fall;
	logic                  sck_rise;
	abs_pkg::abs_ram_req_t cpu_req;
	abs_pkg::abs_ram_req_t eng_req;
	abs_pkg::abs_ram_req_t ram_req;
	logic [7:0]            ram_rdata;

	abs_pkg::abs_mode_t    mode_r;
	abs_pkg::abs_mode_t    mode_nxt;
	logic                  stb_en_r;
	logic                  stb_en_nxt;
	logic                  busy_en_r;
	logic                  busy_en_nxt;
	logic                  busy_lv_r;
	logic                  busy_lv_nxt;
	logic [4:0]            end_r;
	logic [4:0]            end_nxt;
	logic [4:0]            intv_r;
	logic [4:0]            intv_nxt;
	logic                  istat_r;
	logic                  istat_nxt;
	logic                  imask_r;
	logic                  imask_nxt;
	logic [31:0]           prdata_r;
	logic [31:0]           prdata_nxt;
	logic                  ram_sel_r;
	logic                  ram_sel_nxt;

	abs_pkg::abs_state_t   state_r;
	abs_pkg::abs_state_t   state_nxt;
	logic [4:0]            cnt_r;
	logic [4:0]            cnt_nxt;
	logic [7:0]            sr_r;
	logic [7:0]            sr_nxt;
	logic [3:0]            bit_r;
	logic [3:0]            bit_nxt;
	logic [4:0]            gap_r;
	logic [4:0]            gap_nxt;
	logic                  so_r;
	logic                  so_nxt;
	logic                  stb_pend_r;
	logic                  stb_pend_nxt;
	logic                  stb_r;
	logic                  stb_nxt;
	logic                  busy_act_r;
	logic                  busy_act_nxt;
	logic                  done_pend_r;
	logic                  done_pend_nxt;
	logic                  stop_r;
	logic                  stop_nxt;
	logic                  tip_r;
	logic                  tip_nxt;

	logic                  setup;
	logic                  wr_acc;
	logic                  ram_hit;
	logic                  reg_hit;
	logic                  cpu_use;
	logic                  trig_wr;
	logic                  start_ok;
	logic                  last;
	logic                  gap_exit;
	logic                  done_ev;

	abs_sync u_sync (
		.clk_i  (CLK_I),
		.rstn_i (RESETN_I),
		.d_i    ({BUSY_I, SI_I, SCK_I}),
		.q_o    (pins_s)
	);

	assign sck_s    = pins_s[0];
	assign si_s     = pins_s[1];
	assign busy_s   = pins_s[2];
	assign sck_fall = sck_prev_r & ~sck_s;
	assign sck_rise = ~sck_prev_r & sck_s;

	// APB decode; buffer owns bit 7 of the address
	assign setup    = PSEL_I & ~PENABLE_I;
	assign wr_acc   = PSEL_I & PENABLE_I & PWRITE_I;
	assign ram_hit  = PADDR_I[abs_pkg::RAM_SEL_BIT];
	assign reg_hit  = (PADDR_I[7:5] == 3'h0);
	assign cpu_use  = PSEL_I & ram_hit & (PENABLE_I ? PWRITE_I : ~PWRITE_I);
	assign trig_wr  = wr_acc & (PADDR_I == abs_pkg::OFF_TRIG);
	assign start_ok = trig_wr & PWDATA_I[abs_pkg::TRIG_START] & (state_r == abs_pkg::S_IDLE)
		& mode_r.iface_enable & mode_r.auto_mode_enable & mode_r.transmit_enable; // R5 R9 R19

	// CPU wins the buffer port; the engine waits
	always_comb
	begin
		cpu_req       = '0;
		cpu_req.en    = cpu_use;
		cpu_req.we    = PWRITE_I;
		cpu_req.addr  = PADDR_I[6:2];
		cpu_req.wdata = PWDATA_I[7:0];
		ram_req       = cpu_use ? cpu_req : eng_req; // R13
	end

	abs_buf_ram u_ram (
		.clk_i   (CLK_I),
		.rstn_i  (RESETN_I),
		.req_i   (ram_req),
		.rdata_o (ram_rdata)
	);

	// Configuration, interrupt and read data
	always_comb
	begin
		mode_nxt    = mode_r;
		stb_en_nxt  = stb_en_r;
		busy_en_nxt = busy_en_r;
		busy_lv_nxt = busy_lv_r;
		end_nxt     = end_r;
		intv_nxt    = intv_r;
		imask_nxt   = imask_r;
		istat_nxt   = istat_r;
		prdata_nxt  = prdata_r;
		ram_sel_nxt = ram_sel_r;
		if (wr_acc)
		begin
			case (PADDR_I)
			abs_pkg::OFF_MODE:
			begin
				mode_nxt.iface_enable     = PWDATA_I[abs_pkg::MODE_IFACE];
				mode_nxt.auto_mode_enable = PWDATA_I[abs_pkg::MODE_AUTO];
				mode_nxt.repeat_select    = PWDATA_I[abs_pkg::MODE_REPEAT];
				mode_nxt.transmit_enable  = PWDATA_I[abs_pkg::MODE_TX];
				mode_nxt.receive_enable   = PWDATA_I[abs_pkg::MODE_RX];
			end
			abs_pkg::OFF_STATUS:
			begin
				stb_en_nxt  = PWDATA_I[abs_pkg::STAT_STB];
				busy_en_nxt = PWDATA_I[abs_pkg::STAT_BUSY];
				busy_lv_nxt = PWDATA_I[abs_pkg::STAT_BUSYLV];
			end
			abs_pkg::OFF_END:   end_nxt   = PWDATA_I[4:0];
			abs_pkg::OFF_INTV:  intv_nxt  = PWDATA_I[4:0];
			abs_pkg::OFF_ISTAT: istat_nxt = istat_r & ~PWDATA_I[abs_pkg::IRQ_DONE];
			abs_pkg::OFF_IMASK: imask_nxt = PWDATA_I[abs_pkg::IRQ_DONE];
			default:            imask_nxt = imask_r;
			endcase
		end
		if (done_ev)
			istat_nxt = 1'b1; // R3 R7
		if (setup)
		begin
			ram_sel_nxt = ram_hit;
			prdata_nxt  = 32'h0;
			case (PADDR_I)
			abs_pkg::OFF_MODE:   prdata_nxt[7:0] = {mode_r.iface_enable,
				mode_r.auto_mode_enable, mode_r.repeat_select, 1'b0,
				mode_r.transmit_enable, mode_r.receive_enable, 2'h0};
			abs_pkg::OFF_STATUS: prdata_nxt[7:0] = {2'h0, stb_en_r, busy_en_r,
				busy_lv_r, 2'h0, tip_r}; // R8
			abs_pkg::OFF_END:    prdata_nxt[4:0] = end_r;
			abs_pkg::OFF_COUNT:  prdata_nxt[4:0] = cnt_r;
			abs_pkg::OFF_INTV:   prdata_nxt[4:0] = intv_r;
			abs_pkg::OFF_ISTAT:  prdata_nxt[0]   = istat_r;
			abs_pkg::OFF_IMASK:  prdata_nxt[0]   = imask_r;
			default:             prdata_nxt      = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			mode_r    <= abs_pkg::MODE_RST;
			stb_en_r  <= 1'b0;
			busy_en_r <= 1'b0;
			busy_lv_r <= 1'b0;
			end_r     <= abs_pkg::END_RST;
			intv_r    <= abs_pkg::INTV_RST;
			istat_r   <= abs_pkg::IRQ_RST;
			imask_r   <= abs_pkg::IRQ_RST;
			prdata_r  <= 32'h0;
			ram_sel_r <= 1'b0;
		end
		else
		begin
			mode_r    <= mode_nxt;
			stb_en_r  <= stb_en_nxt;
			busy_en_r <= busy_en_nxt;
			busy_lv_r <= busy_lv_nxt;
			end_r     <= end_nxt;
			intv_r    <= intv_nxt;
			istat_r   <= istat_nxt;
			imask_r   <= imask_nxt;
			prdata_r  <= prdata_nxt;
			ram_sel_r <= ram_sel_nxt;
		end
	end

	assign PRDATA_O  = ram_sel_r ? {24'h0, ram_rdata} : prdata_r;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~ram_hit & ~reg_hit;
	assign IRQ_O     = istat_r & imask_r;

	// Transfer sequencer
	assign last     = (cnt_r == end_r); // R16
	assign gap_exit = ~stb_pend_r & ~stb_r & (done_pend_r | ((gap_r == 5'h00) & ~busy_act_r));

	always_comb
	begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		sr_nxt        = sr_r;
		bit_nxt       = bit_r;
		gap_nxt       = gap_r;
		so_nxt        = so_r;
		stb_pend_nxt  = stb_pend_r;
		stb_nxt       = stb_r;
		busy_act_nxt  = busy_act_r;
		done_pend_nxt = done_pend_r;
		stop_nxt      = stop_r;
		tip_nxt       = tip_r;
		eng_req       = '0;
		done_ev       = 1'b0;
		case (state_r)
		abs_pkg::S_IDLE:
		begin
			if (start_ok)
			begin
				cnt_nxt   = 5'h00;
				stop_nxt  = 1'b0;
				tip_nxt   = 1'b1; // R18
				state_nxt = abs_pkg::S_FETCH;
			end
		end
		abs_pkg::S_FETCH:
		begin
			if (!cpu_use)
			begin
				eng_req.en   = 1'b1;
				eng_req.addr = cnt_r; // R2 R11
				state_nxt    = abs_pkg::S_LATCH;
			end
		end
		abs_pkg::S_LATCH:
		begin
			sr_nxt    = ram_rdata; // R2
			bit_nxt   = 4'h0;
			state_nxt = abs_pkg::S_SHIFT;
		end
		abs_pkg::S_SHIFT:
		begin
			if (sck_fall)
			begin
				so_nxt  = sr_r[7]; // R17
				sr_nxt  = {sr_r[6:0], si_s};
				bit_nxt = 4'(bit_r + 4'h1);
				if (bit_r == abs_pkg::LAST_BIT)
					state_nxt = abs_pkg::S_STORE;
			end
		end
		abs_pkg::S_STORE:
		begin
			if (sck_rise && !(cpu_use && mode_r.receive_enable))
			begin
				eng_req.en    = mode_r.receive_enable; // R1 R6 R17
				eng_req.we    = 1'b1;
				eng_req.addr  = cnt_r;
				eng_req.wdata = sr_r;
				if (last && mode_r.repeat_select)
					cnt_nxt = 5'h00; // R10
				else
					cnt_nxt = 5'(cnt_r + 5'h01); // R1 R4 R6
				done_pend_nxt = (last && !mode_r.repeat_select) || stop_r; // R3 R7 R16
				stb_pend_nxt  = stb_en_r;
				busy_act_nxt  = busy_en_r;
				gap_nxt       = intv_r; // R12
				state_nxt     = abs_pkg::S_GAP;
			end
		end
		abs_pkg::S_GAP:
		begin
			if (sck_fall && stb_pend_r)
			begin
				stb_pend_nxt = 1'b0;
				stb_nxt      = 1'b1;
			end
			else if (sck_fall)
				stb_nxt = 1'b0;
			if (sck_rise)
			begin
				busy_act_nxt = busy_en_r && abs_pkg::busy_is_active(busy_lv_r, busy_s); // R12
				if (gap_r != 5'h00)
					gap_nxt = 5'(gap_r - 5'h01); // R12
			end
			if (gap_exit && done_pend_r)
			begin
				done_ev       = 1'b1; // R3 R7
				tip_nxt       = 1'b0; // R3 R8
				so_nxt        = 1'b0;
				done_pend_nxt = 1'b0;
				state_nxt     = abs_pkg::S_IDLE; // R19
			end
			else if (gap_exit)
				state_nxt = abs_pkg::S_FETCH; // R2 R11
		end
		default:
			state_nxt = abs_pkg::S_IDLE;
		endcase
		if (trig_wr && PWDATA_I[abs_pkg::TRIG_STOP] && tip_r)
			stop_nxt = 1'b1;
		if (!mode_r.iface_enable)
		begin
			state_nxt     = abs_pkg::S_IDLE;
			tip_nxt       = 1'b0;
			so_nxt        = 1'b0;
			stb_nxt       = 1'b0;
			stb_pend_nxt  = 1'b0;
			done_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state_r     <= abs_pkg::S_IDLE;
			cnt_r       <= 5'h00;
			sr_r        <= 8'h00;
			bit_r       <= 4'h0;
			gap_r       <= 5'h00;
			so_r        <= 1'b0;
			stb_pend_r  <= 1'b0;
			stb_r       <= 1'b0;
			busy_act_r  <= 1'b0;
			done_pend_r <= 1'b0;
			stop_r      <= 1'b0;
			tip_r       <= 1'b0;
			sck_prev_r  <= 1'b1;
		end
		else
		begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			sr_r        <= sr_nxt;
			bit_r       <= bit_nxt;
			gap_r       <= gap_nxt;
			so_r        <= so_nxt;
			stb_pend_r  <= stb_pend_nxt;
			stb_r       <= stb_nxt;
			busy_act_r  <= busy_act_nxt;
			done_pend_r <= done_pend_nxt;
			stop_r      <= stop_nxt;
			tip_r       <= tip_nxt;
			sck_prev_r  <= sck_s;
		end
	end

	// SO is driven whenever interface and auto mode are on, even without transmit; strobe, input and busy stay free unless in use
	assign SO_O           = so_r;
	assign SO_OE_O        = mode_r.iface_enable & mode_r.auto_mode_enable;
	assign STB_O          = stb_r;
	assign STB_OE_O       = mode_r.iface_enable & stb_en_r; // R14
	assign SI_RELEASE_O   = ~(mode_r.iface_enable & mode_r.receive_enable); // R14
	assign BUSY_RELEASE_O = ~(mode_r.iface_enable & busy_en_r); // R14

	start_tip_a: assert property (start_ok |=> tip_r && state_r == abs_pkg::S_FETCH) // R18
		else $error("start did not raise transfer in progress");
	done_flag_a: assert property (done_ev |=> istat_r && !tip_r && state_r == abs_pkg::S_IDLE) // R3
		else $error("completion did not set flag and clear status");
	repeat_wrap_a: assert property (state_r == abs_pkg::S_STORE && state_nxt == abs_pkg::S_GAP
		&& last && mode_r.repeat_select && !stop_r |=> cnt_r == 5'h00 && !done_pend_r) // R10
		else $error("repeat wrap did not clear counter");
	tx_nowrite_a: assert property (eng_req.en && eng_req.we |-> mode_r.receive_enable
		&& state_r == abs_pkg::S_STORE && sck_rise) // R6
		else $error("buffer written outside a receive store");
	count_step_a: assert property (state_r == abs_pkg::S_STORE && state_nxt == abs_pkg::S_GAP
		&& !last |=> cnt_r == 5'($past(cnt_r) + 5'h01)) // R16
		else $error("counter did not advance by one");
	fetch_first_a: assert property ($rose(state_r == abs_pkg::S_SHIFT)
		|-> $past(state_r, 1) == abs_pkg::S_LATCH && sr_r == $past(ram_rdata)) // R2
		else $error("shift started without buffer load");
	cpu_stall_a: assert property (state_r == abs_pkg::S_FETCH && cpu_use && mode_r.iface_enable
		|=> state_r == abs_pkg::S_FETCH) // R13
		else $error("engine took buffer port from the CPU");
	one_shot_a: assert property (state_r == abs_pkg::S_IDLE && !start_ok
		|=> state_r == abs_pkg::S_IDLE && !tip_r) // R19
		else $error("engine restarted without a trigger");
	gap_hold_a: assert property (state_r == abs_pkg::S_GAP && gap_r != 5'h00 && !done_pend_r
		|=> state_r != abs_pkg::S_FETCH) // R12
		else $error("interval cut short");
	shift_edge_a: assert property (state_r == abs_pkg::S_SHIFT && !sck_fall
		&& mode_r.iface_enable |=> $stable(so_r) && $stable(sr_r)) // R17
		else $error("data moved outside a falling edge");

	done_seen_c: cover property (done_ev);
	wrap_seen_c: cover property (state_r == abs_pkg::S_GAP && cnt_r == 5'h00 && tip_r);
	clash_seen_c: cover property (state_r == abs_pkg::S_FETCH && cpu_use);
	strobe_seen_c: cover property (stb_r ##1 !stb_r);
endmodule : abs_engine
`default_nettype wire

/* File: test/abs_slave_model.sv */
// Serial slave partner: clocks frames, echoes inverted data, frames bytes by strobe
// Assumes strobe enabled and busy active high
`default_nettype none
module abs_slave_model (
	input  wire logic run_i,
	input  wire logic slow_i,
	input  wire logic so_i,
	input  wire logic stb_i,
	output logic      sck_o,
	output logic      si_o,
	output logic      busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic       stb_q;
	int         bsy;
	logic [7:0] got[$];
	initial
	begin
		sck_o = 1'b1;
		si_o = 1'b1;
		busy_o = 1'b0;
		stb_q = 1'b0;
		bsy = 0;
		sh = 8'h00;
	end
	// Clock idles high outside a frame; edges kept clear of system clock edges
	initial
	begin
		#10;
		forever
		begin
			#200 sck_o = ~run_i;
			#200 sck_o = 1'b1;
		end
	end
	// Sample on rising edge, byte boundary from strobe
	always @(posedge sck_o)
	begin
		if (stb_i && !stb_q)
		begin
			got.push_back(sh);
			bsy = slow_i ? 3 : 0;
		end
		else if (bsy > 0)
			bsy--;
		busy_o = (bsy > 0);
		stb_q = stb_i;
		sh = {sh[6:0], so_i};
		si_o = ~so_i;
	end
endmodule : abs_slave_model
`default_nettype wire

/* File: test/tb_abs_engine.sv */
// Self-checking bench: APB tasks drive the engine against the serial slave model
// Assumes a 20 MHz system clock and a 400 ns serial clock
`default_nettype none
module tb_abs_engine;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, sck, si, busy, so, so_oe, stb, stb_oe, si_rel, busy_rel;
	logic        run = 1'b0;
	logic        slow = 1'b0;
	logic        err;
	logic [31:0] q;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [7:0]  tx[6] = '{8'ha5, 8'h3c, 8'h81, 8'h7e, 8'h0f, 8'hf0};
	logic [7:0]  offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

	always #25 clk = ~clk;

	abs_engine DUT (.CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .SCK_I(sck), .SI_I(si),
		.BUSY_I(busy), .SO_O(so), .SO_OE_O(so_oe), .STB_O(stb), .STB_OE_O(stb_oe),
		.SI_RELEASE_O(si_rel), .BUSY_RELEASE_O(busy_rel));

	abs_slave_model slv (.run_i(run), .slow_i(slow), .so_i(so), .stb_i(stb), .sck_o(sck),
		.si_o(si), .busy_o(busy));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd_chk

	task automatic wait_idle(input logic [7:0] pa, input logic [31:0] pe);
		q = 32'h1;
		while (q[0] !== 1'b0)
		begin
			rd_chk(pa, pe);
			apb(1'b0, 8'h04, 32'h0);
		end
	endtask : wait_idle

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			fail_count++;
			stop_test();
		end
	end

	initial
	begin
		logic p;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		foreach (offs[i]) rd_chk(offs[i], 32'h0);
		chk({31'h0, irq}, 32'h0);
		chk({30'h0, stb_oe, so_oe}, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(q, 32'h0);
		$display("test reset done");
		// Transmit-only, six bytes
		for (int i = 0; i < 6; i++)
			wr(8'h80 + 8'(4 * i), {24'h0, tx[i]});
		wr(8'h0c, 32'h5);
		wr(8'h14, 32'h2);
		wr(8'h04, 32'h20);
		wr(8'h1c, 32'h1);
		wr(8'h00, 32'hc8);
		run <= 1'b1;
		wr(8'h08, 32'h1);
		rd_chk(8'h04, 32'h21);
		wait_idle(8'h84, {24'h0, tx[1]});
		run <= 1'b0;
		chk(32'(slv.got.size()), 32'h6);
		for (int i = 0; i < 6; i++)
			chk({24'h0, slv.got[i]}, {24'h0, tx[i]});
		rd_chk(8'h10, 32'h6);
		chk({31'h0, irq}, 32'h1);
		wr(8'h1c, 32'h0);
		rd_chk(8'h18, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(8'h1c, 32'h1);
		wr(8'h18, 32'h1);
		rd_chk(8'h18, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd_chk(8'h80, {24'h0, tx[0]});
		repeat (200) @(posedge clk);
		rd_chk(8'h04, 32'h20);
		$display("test transmit done");
		// Start refused without transmit enable
		wr(8'h00, 32'hc0);
		wr(8'h08, 32'h1);
		rd_chk(8'h04, 32'h20);
		chk({30'h0, si_rel, busy_rel}, 32'h3);
		chk({30'h0, stb_oe, so_oe}, 32'h3);
		$display("test refuse done");
		// Transmit and receive, slow busy partner
		for (int i = 0; i < 3; i++)
			wr(8'h80 + 8'(4 * i), {24'h0, tx[i]});
		wr(8'h0c, 32'h2);
		wr(8'h04, 32'h38);
		wr(8'h00, 32'hcc);
		slow <= 1'b1;
		run <= 1'b1;
		wr(8'h08, 32'h1);
		chk({30'h0, si_rel, busy_rel}, 32'h0);
		wait_idle(8'h00, 32'hcc);
		run <= 1'b0;
		slow <= 1'b0;
		p = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			rd_chk(8'h80 + 8'(4 * i), {24'h0, ~{p, tx[i][7:1]}});
			p = tx[i][0];
		end
		rd_chk(8'h18, 32'h1);
		wr(8'h18, 32'h1);
		$display("test receive done");
		// Repeat transmit of two bytes, then stop
		slv.got.delete();
		for (int i = 0; i < 2; i++)
			wr(8'h80 + 8'(4 * i), {24'h0, tx[i]});
		wr(8'h0c, 32'h1);
		wr(8'h04, 32'h20);
		wr(8'h00, 32'he8);
		run <= 1'b1;
		wr(8'h08, 32'h1);
		while (slv.got.size() < 5)
			@(posedge clk);
		rd_chk(8'h18, 32'h0);
		wr(8'h08, 32'h2);
		wait_idle(8'h00, 32'he8);
		run <= 1'b0;
		for (int i = 0; i < 5; i++)
			chk({24'h0, slv.got[i]}, {24'h0, tx[i % 2]});
		rd_chk(8'h18, 32'h1);
		$display("test repeat done");
		stop_test();
	end
endmodule : tb_abs_engine
`default_nettype wire
